// [core/io_line_config_pwm.sv]
// i/o line function, pull, pwm and sample forwarding configuration
//
// Summary of operation
// R1: line 3 selects disabled, spi select, analog, input, out low, out high
// R2: line 4 accepts 0,1,3,4,5 with 1 as spi mosi; 2 refused
// R3: line 5 value 1 blinks association indicator; 3..5 input or outputs
// R4: line 8 accepts only 0 and 3; sleep request does nothing
// R5: under pin sleep line 8 is the sleep control input always
// R6: under pin sleep all internal pull resistors are off
// R7: pwm a selector: 0 off, 1 signal strength, 2 plain pwm
// R8: bound remote channel zero samples update pwm a duty when plain pwm
// R9: pwm b selector 0 or 2; bound remote samples update its duty
// R10: 64 us pwm period, 10-bit duty, 0 none, 0x3ff full
// R11: host sets selector to pwm then applies settings before use
// R12: through-hole miso enable selector, default off
// R13: surface-mount miso and mosi enables, default on
// R14: surface-mount select, clock and attention enables, default on
// R15: pull enable map bit connects line resistor, default 0xff
// R16: pull direction map picks up or down, default 0xff
// R17: pull settings act only on disabled or input lines
// R18: pull bits: 0 line4, 1 line3, 6 line8, others elsewhere
// R19: forwarding enable sends received samples as api frames, default on
// R20: forwarding matters only when the binding is non-default
// R21: forwarded samples only when api mode is 1 or 2
// R22: api mode 0 raw, 1 framed, 2 framed with escapes
// R23: binding of all 0xff bytes disables line passing
// R24: out-of-range selector writes are refused, config unchanged
`include "io_line_config_pwm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module io_line_config_pwm #(
    parameter int unsigned BLINK_CYCLES = `BLINK_HALF_CYCLES,
    parameter int unsigned NUM_LINES    = 4
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire io_line_config_pwm_pkg::cmd_s    cmd_i,
    input  wire logic                            apply_i,
    output logic                                 rsp_valid_o,
    output logic                                 rsp_err_o,
    output logic [15:0]                          rsp_data_o,
    input  wire logic                            pin_sleep_i,
    input  wire logic                            associated_i,
    input  wire logic [9:0]                      signal_strength_output_duty_i,
    input  wire io_line_config_pwm_pkg::sample_s sample_i,
    input  wire logic [NUM_LINES-1:0]            line_in_i,
    output logic [NUM_LINES-1:0]                 line_oe_o,
    output logic [NUM_LINES-1:0]                 line_out_o,
    output logic [7:0]                           pull_en_o,
    output logic [7:0]                           pull_up_o,
    output io_line_config_pwm_pkg::spi_en_s      spi_en_o,
    output logic                                 pwm_output_a_o,
    output logic                                 pwm_output_b_o,
    output logic                                 fwd_o,
    output logic                                 fwd_escape_o
);
    localparam logic [11:0] PWM_CYC = 12'(`PWM_PERIOD_CYCLES);
    // --------
    // functions
    // --------
    // reset value of each configuration register
    function automatic logic [15:0] reset_val(input logic [4:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            `IDX_LINE5_SEL:  v = `RST_LINE5_SEL;
            `IDX_PWM_A_SEL:  v = `RST_PWM_A_SEL;
            `IDX_SMT_MISO, `IDX_SMT_MOSI, `IDX_SMT_SELECT,
            `IDX_SMT_SCLK, `IDX_SMT_ATTN: v = `RST_SMT_ENABLE;
            `IDX_PULL_EN, `IDX_PULL_DIR:  v = `RST_PULL_MAP;
            `IDX_FWD_EN:     v = `RST_FWD_EN;
            `IDX_BIND_W0, `IDX_BIND_W1,
            `IDX_BIND_W2, `IDX_BIND_W3:   v = `RST_BIND_WORD;
            default:         v = 16'h0000;
        endcase
        return v;
    endfunction

    // write legality per register
    function automatic logic write_ok(input logic [4:0]  idx,
                                      input logic [15:0] d);
        logic ok;
        ok = 1'b0;
        case (idx)
            // R1: line 3 range
            `IDX_LINE3_SEL:  ok = (d <= 16'h0005);
            // R2: line 4 skips analog
            `IDX_LINE4_SEL:  ok = (d <= 16'h0005) && (d != 16'h0002);
            `IDX_LINE5_SEL:  ok = (d <= 16'h0005) && (d != 16'h0002);
            // R4: line 8 only 0 or 3
            `IDX_LINE8_SEL:  ok = (d == 16'h0000) || (d == 16'h0003);
            `IDX_PWM_A_SEL:  ok = (d <= 16'h0002);
            `IDX_PWM_B_SEL:  ok = (d == 16'h0000) || (d == 16'h0002);
            `IDX_TH_MISO, `IDX_SMT_MISO, `IDX_SMT_MOSI, `IDX_SMT_SELECT,
            `IDX_SMT_SCLK, `IDX_SMT_ATTN, `IDX_FWD_EN: ok = (d <= 16'h0001);
            `IDX_PWM_A_DUTY, `IDX_PWM_B_DUTY: ok = (d <= `DUTY_MAX);
            `IDX_PULL_EN, `IDX_PULL_DIR: ok = (d <= `MAP_MAX);
            `IDX_BIND_W0, `IDX_BIND_W1, `IDX_BIND_W2, `IDX_BIND_W3: ok = 1'b1;
            // R22: api mode 0..2
            `IDX_API_MODE:   ok = (d <= 16'h0002);
            default:         ok = 1'b0;
        endcase
        return ok;
    endfunction

    // pull settings apply only to disabled or input lines
    function automatic logic pull_ok(input logic [15:0] fn);
        return (fn == io_line_config_pwm_pkg::FN_DISABLED) ||
               (fn == io_line_config_pwm_pkg::FN_INPUT);
    endfunction
    // --------
    // input synchronisers
    // --------
    logic                 sleep_m_q;
    logic                 sleep_s_q;
    logic [NUM_LINES-1:0] line_m_q;
    logic [NUM_LINES-1:0] line_s_q;

    // two flops on the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_m_q <= 1'b0;
            sleep_s_q <= 1'b0;
            line_m_q  <= '0;
            line_s_q  <= '0;
        end else begin
            sleep_m_q <= pin_sleep_i;
            sleep_s_q <= sleep_m_q;
            line_m_q  <= line_in_i;
            line_s_q  <= line_m_q;
        end
    end
    // --------
    // configuration storage: pending and applied copies
    // --------
    logic [15:0] pend_q [`NUM_CFG_REGS];
    logic [15:0] act_q  [`NUM_CFG_REGS];
    logic        wr_go;
    logic        pass_en;
    logic        bound;
    logic        upd_a;
    logic        upd_b;
    logic [63:0] bind_w;

    assign wr_go  = cmd_i.valid && cmd_i.write &&
                    write_ok(cmd_i.idx, cmd_i.data);
    assign bind_w = {act_q[`IDX_BIND_W3], act_q[`IDX_BIND_W2],
                     act_q[`IDX_BIND_W1], act_q[`IDX_BIND_W0]};
    // R23: all ones turns passing off
    assign pass_en = (bind_w != `BIND_OFF);
    assign bound   = pass_en && sample_i.valid &&
                     ((bind_w == `BIND_ANY) || (sample_i.src == bind_w));
    // R8: channel zero drives pwm a when plain pwm
    assign upd_a = bound && (act_q[`IDX_PWM_A_SEL] == 16'h0002);
    // R9: pwm b follows remote analog samples
    assign upd_b = bound && (act_q[`IDX_PWM_B_SEL] == 16'h0002);

    // pending copy takes legal writes; samples win over a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `NUM_CFG_REGS; i++) begin
                pend_q[i] <= reset_val(5'(i));
            end
        end else begin
            // R24: illegal values leave storage unchanged
            if (wr_go) begin
                pend_q[cmd_i.idx] <= cmd_i.data;
            end
            if (upd_a) begin
                pend_q[`IDX_PWM_A_DUTY] <= {6'h00, sample_i.ad0};
            end
            if (upd_b) begin
                pend_q[`IDX_PWM_B_DUTY] <= {6'h00, sample_i.ad1};
            end
        end
    end

    // applied copy follows pending on the apply command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `NUM_CFG_REGS; i++) begin
                act_q[i] <= reset_val(5'(i));
            end
        end else begin
            // R11: new config only after apply
            if (apply_i) begin
                for (int i = 0; i < `NUM_CFG_REGS; i++) begin
                    act_q[i] <= pend_q[i];
                end
            end
            if (upd_a) begin
                act_q[`IDX_PWM_A_DUTY] <= {6'h00, sample_i.ad0};
            end
            if (upd_b) begin
                act_q[`IDX_PWM_B_DUTY] <= {6'h00, sample_i.ad1};
            end
        end
    end
    // --------
    // command answer
    // --------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_err_o   <= 1'b0;
            rsp_data_o  <= 16'h0000;
        end else begin
            rsp_valid_o <= cmd_i.valid;
            rsp_err_o   <= cmd_i.valid && cmd_i.write && !wr_go;
            if (cmd_i.valid && !cmd_i.write) begin
                if (cmd_i.idx == `IDX_STATUS) begin
                    rsp_data_o <= {10'h000, associated_i, sleep_s_q,
                                   4'(line_s_q)};
                end else if (cmd_i.idx < 5'(`NUM_CFG_REGS)) begin
                    rsp_data_o <= pend_q[cmd_i.idx];
                end else begin
                    rsp_data_o <= 16'h0000;
                end
            end
        end
    end
    // --------
    // association blink
    // --------
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    // R3: toggles only while associated
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else if (!associated_i) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end
    // --------
    // line drivers: 0 line 3, 1 line 4, 2 line 5, 3 line 8
    // --------
    logic [15:0] line_fn [NUM_LINES];
    assign line_fn[0] = act_q[`IDX_LINE3_SEL];
    assign line_fn[1] = act_q[`IDX_LINE4_SEL];
    assign line_fn[2] = act_q[`IDX_LINE5_SEL];
    assign line_fn[3] = act_q[`IDX_LINE8_SEL];

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_line
            // R1: output codes drive the pin
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    line_oe_o[g]  <= 1'b0;
                    line_out_o[g] <= 1'b0;
                end else if (g == 3 && sleep_s_q) begin
                    // R5: sleep control input
                    line_oe_o[g]  <= 1'b0;
                    line_out_o[g] <= 1'b0;
                end else begin
                    case (line_fn[g])
                        io_line_config_pwm_pkg::FN_OUT_LOW: begin
                            line_oe_o[g]  <= 1'b1;
                            line_out_o[g] <= 1'b0;
                        end
                        io_line_config_pwm_pkg::FN_OUT_HIGH: begin
                            line_oe_o[g]  <= 1'b1;
                            line_out_o[g] <= 1'b1;
                        end
                        io_line_config_pwm_pkg::FN_SPECIAL: begin
                            // R3: indicator on line 5 only
                            line_oe_o[g]  <= (g == 2);
                            line_out_o[g] <= (g == 2) && blink_q;
                        end
                        default: begin
                            line_oe_o[g]  <= 1'b0;
                            line_out_o[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate
    // --------
    // pull resistors
    // --------
    logic [7:0] pull_gate;
    // R17: gate by line function
    always_comb begin
        pull_gate = 8'hff;
        // R18: map bits to lines
        pull_gate[`PULL_BIT_LINE4] = pull_ok(line_fn[1]);
        pull_gate[`PULL_BIT_LINE3] = pull_ok(line_fn[0]);
        pull_gate[`PULL_BIT_LINE8] = pull_ok(line_fn[3]);
    end

    // R15: enable map, R16: direction map
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_en_o <= 8'h00;
            pull_up_o <= 8'h00;
        end else begin
            // R6: pin sleep overrides pulls
            pull_en_o <= sleep_s_q ? 8'h00 :
                         (act_q[`IDX_PULL_EN][7:0] & pull_gate);
            pull_up_o <= act_q[`IDX_PULL_DIR][7:0];
        end
    end
    // --------
    // serial-peripheral enables
    // --------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_en_o <= '0;
        end else begin
            // R1: line 3 slave select
            spi_en_o.th_select  <= (line_fn[0] == 16'h0001);
            // R2: line 4 mosi
            spi_en_o.th_mosi    <= (line_fn[1] == 16'h0001);
            // R12: through-hole miso
            spi_en_o.th_miso    <= act_q[`IDX_TH_MISO][0];
            // R13: surface-mount data lines
            spi_en_o.smt_miso   <= act_q[`IDX_SMT_MISO][0];
            spi_en_o.smt_mosi   <= act_q[`IDX_SMT_MOSI][0];
            // R14: surface-mount control lines
            spi_en_o.smt_select <= act_q[`IDX_SMT_SELECT][0];
            spi_en_o.smt_sclk   <= act_q[`IDX_SMT_SCLK][0];
            spi_en_o.smt_attn   <= act_q[`IDX_SMT_ATTN][0];
        end
    end
    // --------
    // pwm outputs
    // --------
    logic [11:0] pwm_cnt_q;
    logic [21:0] phase;
    logic [9:0]  duty_a;
    logic [9:0]  duty_b;
    // R10: 64 us period counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_cnt_q <= 12'h000;
        end else if (pwm_cnt_q == PWM_CYC - 12'h001) begin
            pwm_cnt_q <= 12'h000;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 12'h001;
        end
    end

    assign phase  = 22'(pwm_cnt_q) * 22'(`PWM_STEPS);
    // R7: signal strength or stored duty
    assign duty_a = (act_q[`IDX_PWM_A_SEL] == 16'h0001) ?
                    signal_strength_output_duty_i : act_q[`IDX_PWM_A_DUTY][9:0];
    assign duty_b = act_q[`IDX_PWM_B_DUTY][9:0];

    // R10: high while step below duty
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_output_a_o <= 1'b0;
            pwm_output_b_o <= 1'b0;
        end else begin
            pwm_output_a_o <= (act_q[`IDX_PWM_A_SEL] != 16'h0000) &&
                              (phase < 22'(duty_a) * 22'(PWM_CYC));
            pwm_output_b_o <= (act_q[`IDX_PWM_B_SEL] == 16'h0002) &&
                              (phase < 22'(duty_b) * 22'(PWM_CYC));
        end
    end
    // --------
    // sample forwarding to the host
    // --------
    logic [15:0] api_mode;
    assign api_mode = act_q[`IDX_API_MODE];
    // forward strobe and framing mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_o        <= 1'b0;
            fwd_escape_o <= 1'b0;
        end else begin
            // R19: enable, R20: bound, R21: framed mode
            fwd_o <= bound && act_q[`IDX_FWD_EN][0] &&
                     ((api_mode == 16'h0001) || (api_mode == 16'h0002));
            // R22: escaped framing
            fwd_escape_o <= (api_mode == 16'h0002);
        end
    end

endmodule

`default_nettype wire

// [include/io_line_config_pwm_defs.svh]
// register indices, reset values and timing counts of the i/o line block
`ifndef IO_LINE_CONFIG_PWM_DEFS_SVH
`define IO_LINE_CONFIG_PWM_DEFS_SVH

// ----------------------------------------------------------------
// register indices on the command port
// ----------------------------------------------------------------
`define IDX_LINE3_SEL      5'h00
`define IDX_LINE4_SEL      5'h01
`define IDX_LINE5_SEL      5'h02
`define IDX_LINE8_SEL      5'h03
`define IDX_PWM_A_SEL      5'h04
`define IDX_PWM_B_SEL      5'h05
`define IDX_TH_MISO        5'h06
`define IDX_PWM_A_DUTY     5'h07
`define IDX_PWM_B_DUTY     5'h08
`define IDX_SMT_MISO       5'h09
`define IDX_SMT_MOSI       5'h0a
`define IDX_SMT_SELECT     5'h0b
`define IDX_SMT_SCLK       5'h0c
`define IDX_SMT_ATTN       5'h0d
`define IDX_PULL_EN        5'h0e
`define IDX_PULL_DIR       5'h0f
`define IDX_FWD_EN         5'h10
`define IDX_BIND_W0        5'h11
`define IDX_BIND_W1        5'h12
`define IDX_BIND_W2        5'h13
`define IDX_BIND_W3        5'h14
`define IDX_API_MODE       5'h15
`define IDX_STATUS         5'h16
`define NUM_CFG_REGS       22

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_LINE3_SEL      16'h0000
`define RST_LINE4_SEL      16'h0000
`define RST_LINE5_SEL      16'h0001
`define RST_LINE8_SEL      16'h0000
`define RST_PWM_A_SEL      16'h0001
`define RST_PWM_B_SEL      16'h0000
`define RST_TH_MISO        16'h0000
`define RST_DUTY           16'h0000
`define RST_SMT_ENABLE     16'h0001
`define RST_PULL_MAP       16'h00ff
`define RST_FWD_EN         16'h0001
`define RST_BIND_WORD      16'hffff
`define RST_API_MODE       16'h0000

// ----------------------------------------------------------------
// field limits and codes
// ----------------------------------------------------------------
`define DUTY_MAX           16'h03ff
`define MAP_MAX            16'h00ff
`define BIND_ANY           64'h0000_0000_0000_ffff
`define BIND_OFF           64'hffff_ffff_ffff_ffff
`define PULL_BIT_LINE4     0
`define PULL_BIT_LINE3     1
`define PULL_BIT_LINE8     6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define PWM_PERIOD_NS      64000
`define PWM_PERIOD_CYCLES  (`PWM_PERIOD_NS / `CLK_PERIOD_NS)
`define PWM_STEPS          1023
`define BLINK_HALF_NS      250000000
`define BLINK_HALF_CYCLES  (`BLINK_HALF_NS / `CLK_PERIOD_NS)

`endif

// [include/io_line_config_pwm_pkg.sv]
// types shared by the i/o line configuration block
package io_line_config_pwm_pkg;

    // line function selector codes
    typedef enum logic [15:0] {
        FN_DISABLED = 16'h0000,
        FN_SPECIAL  = 16'h0001,
        FN_ANALOG   = 16'h0002,
        FN_INPUT    = 16'h0003,
        FN_OUT_LOW  = 16'h0004,
        FN_OUT_HIGH = 16'h0005
    } line_fn_e;

    // command from the host side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  idx;
        logic [15:0] data;
    } cmd_s;

    // remote sample received by the radio side
    typedef struct packed {
        logic        valid;
        logic [63:0] src;
        logic [9:0]  ad0;
        logic [9:0]  ad1;
    } sample_s;

    // serial-peripheral function enables
    typedef struct packed {
        logic th_select;
        logic th_mosi;
        logic th_miso;
        logic smt_miso;
        logic smt_mosi;
        logic smt_select;
        logic smt_sclk;
        logic smt_attn;
    } spi_en_s;

endpackage

// [verif/io_line_config_pwm_sva.sv]
// port checker for the i/o line block
`include "io_line_config_pwm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module line_cfg_sva #(
    parameter int unsigned NUM_LINES = 4
) (
    input wire logic                            clk_i,
    input wire logic                            rst_i,
    input wire io_line_config_pwm_pkg::cmd_s    cmd_i,
    input wire io_line_config_pwm_pkg::sample_s sample_i,
    input wire logic                            pin_sleep_i,
    input wire logic                            rsp_valid_o,
    input wire logic                            rsp_err_o,
    input wire logic [NUM_LINES-1:0]            line_oe_o,
    input wire logic [7:0]                      pull_en_o,
    input wire logic                            fwd_o
);
    // ------
    // refused selector writes
    // ------
    wire logic [4:0]  ix   = cmd_i.idx;
    wire logic [15:0] dt   = cmd_i.data;
    wire logic        wr   = cmd_i.valid && cmd_i.write;
    wire logic        bad4 = wr && ix == `IDX_LINE4_SEL && dt == 16'h2;
    wire logic        bad8 = wr && ix == `IDX_LINE8_SEL && !(dt inside {0, 3});
    wire logic        badb = wr && ix == `IDX_PWM_B_SEL && dt == 16'h1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------
    // properties
    // ------
    sequence s_sleep; pin_sleep_i [*4]; endsequence
    property p_rsp; cmd_i.valid |=> rsp_valid_o; endproperty
    property p_l4; bad4 |=> rsp_valid_o && rsp_err_o; endproperty
    property p_l8; bad8 |=> rsp_err_o; endproperty
    property p_pb; badb |=> rsp_err_o; endproperty
    property p_pull; s_sleep |-> pull_en_o == 8'h00; endproperty
    property p_oe; s_sleep |-> !line_oe_o[NUM_LINES-1]; endproperty
    property p_fwd; fwd_o |-> $past(sample_i.valid); endproperty
    property p_gate; line_oe_o[1] |-> !pull_en_o[`PULL_BIT_LINE4]; endproperty
    a_rsp: assert property (p_rsp) else $error("no response");
    a_l4: assert property (p_l4) else $error("line 4 code 2 taken");
    a_l8: assert property (p_l8) else $error("line 8 code taken");
    a_pb: assert property (p_pb) else $error("pwm b code 1 taken");
    a_pull: assert property (p_pull) else $error("pull on in sleep");
    a_oe: assert property (p_oe) else $error("line 8 driven");
    a_fwd: assert property (p_fwd) else $error("stray forward");
    a_gate: assert property (p_gate) else $error("pull on output");
endmodule
bind io_line_config_pwm line_cfg_sva #(.NUM_LINES(NUM_LINES)) chk_u (
    .clk_i, .rst_i, .cmd_i, .sample_i, .pin_sleep_i, .rsp_valid_o,
    .rsp_err_o, .line_oe_o, .pull_en_o, .fwd_o
);
`default_nettype wire

// [verif/host_model.sv]
// host side model issuing configuration commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                    clk_i,
    output io_line_config_pwm_pkg::cmd_s cmd_o,
    output logic                         apply_o
);
    initial begin
        cmd_o = '0;
        apply_o = 1'b0;
    end
    // one command for one cycle, then scrambled lines and a gap
    task automatic send(input logic w, input logic [4:0] i,
                        input logic [15:0] d, input int gap);
        @(posedge clk_i);
        cmd_o <= '{1'b1, w, i, d};
        @(posedge clk_i);
        cmd_o <= '{1'b0, ~w, ~i, ~d};
        repeat (gap) @(posedge clk_i);
    endtask
    task automatic apply();
        @(posedge clk_i);
        apply_o <= 1'b1;
        @(posedge clk_i);
        apply_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/io_line_config_pwm_tb.sv]
// self-checking bench for the i/o line block
`include "io_line_config_pwm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module io_line_config_pwm_tb;
    logic        clk_i, rst_i, apply_i, pin_sleep_i, associated_i;
    logic        rsp_valid_o, rsp_err_o, fwd_o, fwd_escape_o;
    logic        pwm_output_a_o, pwm_output_b_o;
    logic [15:0] rsp_data_o, d, ca, cb, ce;
    logic [9:0]  signal_strength_output_duty_i;
    logic [3:0]  line_in_i, line_oe_o, line_out_o;
    logic [7:0]  pull_en_o, pull_up_o;
    logic [17:0] e, exp_q[$];
    io_line_config_pwm_pkg::cmd_s    cmd_i;
    io_line_config_pwm_pkg::sample_s sample_i;
    io_line_config_pwm_pkg::spi_en_s spi_en_o;
    int error_cnt = 0, comparisons = 0, seed = 95, n, k, v;
    int rv[22] = '{0, 0, 1, 0, 1, 0, 0, 0, 0, 1, 1, 1, 1, 1, 'hff, 'hff, 1,
                   'hffff, 'hffff, 'hffff, 'hffff, 0};
    int ix[14] = '{0, 1, 2, 3, 4, 5, 6, 9, 10, 11, 12, 13, 16, 21};
    int lg[14] = '{'h3f, 'h3b, 'h3b, 'h9, 7, 5, 3, 3, 3, 3, 3, 3, 3, 7};
    int dt[3] = '{0, 'h1ff, 'h3ff};
    int fa[4] = '{'hd, 2, 1, 'hb};
    io_line_config_pwm #(.BLINK_CYCLES(4)) dut_u (
        .clk_i, .rst_i, .cmd_i, .apply_i, .rsp_valid_o, .rsp_err_o,
        .rsp_data_o, .pin_sleep_i, .associated_i, .signal_strength_output_duty_i, .sample_i,
        .line_in_i, .line_oe_o, .line_out_o, .pull_en_o, .pull_up_o,
        .spi_en_o, .pwm_output_a_o, .pwm_output_b_o, .fwd_o, .fwd_escape_o
    );
    host_model host_u (.clk_i, .cmd_o(cmd_i), .apply_o(apply_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // random levels on status inputs
    always @(posedge clk_i) begin
        associated_i <= $random(seed);
        signal_strength_output_duty_i <= $random(seed);
        line_in_i <= $random(seed);
    end
    // ------
    // checking
    // ------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // note the expected answer, then hand the command to the host
    task automatic op(input logic w, input int i, input int v, input logic r);
        exp_q.push_back({w, r, w ? 16'h0 : v[15:0]});
        host_u.send(w, i[4:0], w ? v[15:0] : 16'h0, $random(seed) & 1);
    endtask
    // one remote sample, then the forward pulse
    task automatic smp(input logic f);
        d = $random(seed);
        @(posedge clk_i);
        sample_i <= '{1'b1, {$random(seed), $random(seed)}, d[9:0], ~d[9:0]};
        @(posedge clk_i);
        sample_i <= {1'b0, ~sample_i[83:0]};
        @(posedge clk_i);
        chk({15'h0, fwd_o}, {15'h0, f});
    endtask
    // oldest note against each response
    always @(posedge clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 18'h3ffff;
            chk({15'h0, rsp_err_o}, {15'h0, e[16]});
            if (!e[17]) chk(rsp_data_o, e[15:0]);
        end
    end
    // ------
    // main sequence
    // ------
    initial begin
        rst_i = 1'b1;
        pin_sleep_i = 1'b0;
        associated_i = 1'b0;
        signal_strength_output_duty_i = 10'h000;
        line_in_i = 4'h0;
        sample_i = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({line_oe_o, 4'h0, spi_en_o}, 16'h401f);
        for (n = 0; n < 22; n++) op(0, n, rv[n], 0);
        // every code of every selector; refused ones keep the old value
        foreach (ix[j]) begin
            v = rv[ix[j]];
            for (n = 0; n < 7; n++) begin
                if (lg[j][n]) v = n;
                op(1, ix[j], n, !lg[j][n]);
                op(0, ix[j], v, 0);
            end
        end
        op(1, 'h17, 1, 1);
        host_u.apply();
        repeat (5) @(posedge clk_i);
        chk({line_oe_o, line_out_o, pull_en_o}, 16'h77fc);
        chk({spi_en_o, pull_up_o}, 16'h3fff);
        chk({15'h0, fwd_escape_o}, 16'h1);
        // high time over one whole period for each duty
        foreach (dt[j]) begin
            op(1, 7, dt[j], 0);
            op(1, 8, dt[j], 0);
            host_u.apply();
            repeat (4) @(posedge clk_i);
            {ca, cb, ce} = '0;
            for (n = 0; n < `PWM_PERIOD_CYCLES; n++) begin
                @(posedge clk_i);
                ca += pwm_output_a_o;
                cb += pwm_output_b_o;
                ce += 16'(n * `PWM_STEPS < dt[j] * `PWM_PERIOD_CYCLES);
            end
            chk(ca, ce);
            chk(cb, ce);
        end
        smp(1'b0);
        op(0, 7, 'h3ff, 0);
        for (n = 18; n < 21; n++) op(1, n, 0, 0);
        // bound to any source: walk forward enable and api mode
        foreach (fa[j]) begin
            op(1, 16, fa[j] & 1, 0);
            op(1, 21, fa[j] >> 1 & 3, 0);
            host_u.apply();
            smp(fa[j][3]);
            op(0, 7, d[9:0], 0);
            op(0, 8, ~d[9:0] & 'h3ff, 0);
        end
        pin_sleep_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk({pull_en_o, 7'h0, line_oe_o[3]}, 16'h0);
        for (k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk_i);
        if (exp_q.size() != 0) chk(16'h1, 16'h0);
        results();
    end
endmodule
`default_nettype wire
